// File: verilog/two_wire_port_regs.svh
// Constants of the two-wire command port: commands, bus map, timing.
// Assumes inclusion by bare name from the package, compiled ahead of the design modules.
`ifndef TWO_WIRE_PORT_REGS_SVH
`define TWO_WIRE_PORT_REGS_SVH

// ----------------------------------------
// Serial frame layout.
// ----------------------------------------
`define FRAME_LAST    4'hf
`define HEAD_LAST     4'h7
`define LOW_RUN       6'h20
`define CMD_REINIT    16'h8d00
`define CMD_OFF       16'h8d02
`define CMD_CORE      16'hbd01
`define ADDR_W        6
`define DATA_W        8

// ----------------------------------------
// Register map on the AXI4-Lite slave.
// ----------------------------------------
`define AXI_AW        8
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define CTRL_RISE_BIT 0
`define CTRL_STOP_LSB 8
`define CTRL_RISE_RST 1'h1
`define CTRL_STOP_RST 7'h02
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

// ----------------------------------------
// Timing: one millisecond in ns, clock period in ns.
// ----------------------------------------
`define MS_NS         1000000
`define CLK_NS        8
`define MS_CYCLES     (`MS_NS / `CLK_NS)
`define MS_DIV_W      17

`endif

// File: verilog/two_wire_port_pkg.sv
// Types shared by the two-wire command port modules.
// Assumes the constants header is on the include path.
`include "two_wire_port_regs.svh"

package two_wire_port_pkg;

	// Frame decoder states.
	typedef enum logic [2:0]
	{
		FR_IDLE  = 3'h0,
		FR_HEAD  = 3'h1,
		FR_WDATA = 3'h2,
		FR_RDATA = 3'h3,
		FR_TAIL  = 3'h4
	} frame_state_t;

	// Transmit engine modes.
	typedef enum logic
	{
		MD_SLEEP = 1'h0,
		MD_TX    = 1'h1
	} tx_mode_t;

	// One write into the register array.
	typedef struct packed
	{
		logic                 en;
		logic [`ADDR_W-1:0]   addr;
		logic [`DATA_W-1:0]   data;
	} rf_wr_t;

	// Synchronised levels and edges of the two pins.
	typedef struct packed
	{
		logic                 lvl;
		logic                 rise;
		logic                 fall;
	} pin_edges_t;

endpackage

// File: verilog/pin_sync.sv
// Two-flop synchronisers and edge finders for the serial pins.
// Assumes asynchronous pins and one fast system clock.
`timescale 1ns/100ps
`default_nettype none

module pin_sync
	import two_wire_port_pkg::*;
(
	input  wire logic       clock_i,
	input  wire logic       reset_n_i,
	input  wire logic [1:0] pin_i,
	output pin_edges_t      edge_o [2]
);

	// ----------------------------------------
	// One chain per pin.
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1)
		begin : g_pin
			logic meta_ff;   // First stage, read only by the second.
			logic sync_ff;   // Settled level.
			logic prev_ff;   // Level one cycle ago, for edges.

			// Plain shift chain; edges compare the settled stages only.
			always_ff @(posedge clock_i or negedge reset_n_i)
			begin
				if (!reset_n_i)
				begin
					// Each chain resets to its pin's idle level: the clock line
					// idles high, so a low reset would fake a rise on release.
					meta_ff <= 1'(g);
					sync_ff <= 1'(g);
					prev_ff <= 1'(g);
				end
				else
				begin
					meta_ff <= pin_i[g];
					sync_ff <= meta_ff;
					prev_ff <= sync_ff;
				end
			end

			assign edge_o[g].lvl  = sync_ff;
			assign edge_o[g].rise = sync_ff & ~prev_ff;
			assign edge_o[g].fall = ~sync_ff & prev_ff;
		end
	endgenerate

endmodule // pin_sync

`default_nettype wire

// File: verilog/cfg_reg_array.sv
// Sixty-four byte configuration registers behind the serial port.
// Assumes one write per cycle and a synchronous clear from core reset.
`timescale 1ns/100ps
`default_nettype none

module cfg_reg_array
	import two_wire_port_pkg::*;
(
	input  wire logic               clock_i,
	input  wire logic               reset_n_i,
	input  wire logic               clear_i,
	input  wire rf_wr_t             wr_i,
	input  wire logic [`ADDR_W-1:0] rd_addr_i,
	output logic      [`DATA_W-1:0] rd_data_o
);

	logic [`DATA_W-1:0] mem_ff [64];   // The register bytes.

	// ----------------------------------------
	// One byte per entry.
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 64; g = g + 1)
		begin : g_ent
			wire hit = wr_i.en & (wr_i.addr == 6'(g));   // Entry selected.

			// Clear wins: core reset leaves nothing half written.
			always_ff @(posedge clock_i or negedge reset_n_i)
			begin
				if (!reset_n_i)
					mem_ff[g] <= 8'h00;
				else if (clear_i)
					mem_ff[g] <= 8'h00;
				else if (hit)
					mem_ff[g] <= wr_i.data;
			end
		end
	endgenerate

	assign rd_data_o = mem_ff[rd_addr_i];

endmodule // cfg_reg_array

`default_nettype wire

// File: verilog/two_wire_command_port.sv
// Device end of the two-wire command and register port.
// Assumes a host that owns the serial clock; pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none

module two_wire_command_port
	import two_wire_port_pkg::*;
#(
	parameter int MS_CYCLES = `MS_CYCLES   // Clocks per millisecond.
)
(
	input  wire logic              clock_i,
	input  wire logic              reset_n_i,
	input  wire logic              sclk_i,
	input  wire logic              sdat_i,
	output logic                   sdat_o,
	output logic                   sdat_oe_o,
	output logic                   tx_start_o,
	output logic                   core_reset_o,
	output logic                   sleep_o,
	input  wire logic [`AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [`AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready
);

	// ----------------------------------------
	// Pin synchronisers.
	// ----------------------------------------
	pin_edges_t pe [2];   // Index 0 data line, 1 clock line.

	pin_sync u_sync
	(
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.pin_i     ({sclk_i, sdat_i}),
		.edge_o    (pe)
	);

	wire sclk_fall = pe[1].fall;   // Sample point of every bit.
	wire sclk_rise = pe[1].rise;   // Launch point of read bits.
	wire bit_in    = pe[0].lvl;    // Data level at the sample point.

	// ----------------------------------------
	// State.
	// ----------------------------------------
	frame_state_t       state_ff;     // Frame decoder state.
	logic [3:0]         cnt_ff;       // Bits taken so far in this frame.
	logic [15:0]        shift_ff;     // Incoming bits, first bit on top.
	logic [5:0]         zrun_ff;      // Run of low samples, saturating.
	logic               cand_ff;      // Frame follows a long low run.
	logic [7:0]         rd_sh_ff;     // Read data on its way out.
	logic               oe_ff;        // Data line driven by us.
	logic               dout_ff;      // Level we drive.
	logic               port_on_ff;   // Serial port accepts frames.
	logic               armed_ff;     // Data edges may start sending.
	tx_mode_t           mode_ff;      // Sleeping or sending.
	logic               start_ff;     // One-cycle start pulse.
	logic               core_ff;      // One-cycle core reset pulse.
	logic [16:0]        ms_div_ff;    // Millisecond divider.
	logic [6:0]         lo_ms_ff;     // Whole ms of low data line.
	logic               rise_cfg_ff;  // Start on rising data edge.
	logic [6:0]         stop_cfg_ff;  // Stop hold time in ms.
	logic               bvalid_ff;    // Write answer pending.
	logic [1:0]         bresp_ff;     // Write answer code.
	logic               rvalid_ff;    // Read answer pending.
	logic [1:0]         rresp_ff;     // Read answer code.
	logic [31:0]        rdata_ff;     // Read answer data.

	// ----------------------------------------
	// Frame decode terms.
	// ----------------------------------------
	wire long_low  = (zrun_ff == `LOW_RUN);
	wire [15:0] word = {shift_ff[14:0], bit_in};
	wire [7:0] head = word[7:0];
	wire head_end  = sclk_fall & (state_ff == FR_HEAD) & (cnt_ff == `HEAD_LAST);
	wire frame_end = sclk_fall & (state_ff == FR_WDATA) & (cnt_ff == `FRAME_LAST);
	wire is_read   = head[6] & port_on_ff & ~cand_ff;
	wire normal    = frame_end & ~cand_ff & port_on_ff;
	wire is_reinit = frame_end & cand_ff & (word == `CMD_REINIT);
	wire is_off    = normal & (word == `CMD_OFF);
	wire is_core   = normal & (word == `CMD_CORE);
	wire is_wr     = normal & ~word[14] & ~is_off & ~is_core;
	wire abort     = sclk_fall & long_low & ~bit_in & (state_ff != FR_IDLE);
	wire begin_ok  = port_on_ff | long_low;

	rf_wr_t       rf_wr;       // Register write from a write frame.
	logic [7:0]   rf_rdata;    // Addressed register contents.

	assign rf_wr.en   = is_wr;
	assign rf_wr.addr = word[13:8];
	assign rf_wr.data = word[7:0];

	cfg_reg_array u_regs
	(
		.clock_i   (clock_i),
		.reset_n_i (reset_n_i),
		.clear_i   (is_core),
		.wr_i      (rf_wr),
		.rd_addr_i (head[5:0]),
		.rd_data_o (rf_rdata)
	);

	// ----------------------------------------
	// Low-run counter, the port-reset preamble.
	// ----------------------------------------
	// Counts on falls only, so a stopped clock holds the run.
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			zrun_ff <= 6'h00;
		else if (sclk_fall)
			zrun_ff <= bit_in ? 6'h00 : (long_low ? zrun_ff : zrun_ff + 6'h01);
	end

	// ----------------------------------------
	// Frame state machine, advanced on falls; the tail ends on a rise.
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_ff <= FR_IDLE;
			cnt_ff   <= 4'h0;
			shift_ff <= 16'h0000;
			cand_ff  <= 1'h0;
		end
		else if (abort)
			state_ff <= FR_IDLE;    // A long low run resynchronises.
		else if (sclk_fall)
		begin
			shift_ff <= word;
			cnt_ff   <= cnt_ff + 4'h1;
			unique case (state_ff)
				FR_IDLE:
				begin
					cnt_ff <= 4'h0;
					// A one starts a frame while the port is on or after a long low run; zeros are idle or preamble.
					if (bit_in & begin_ok)
					begin
						cnt_ff   <= 4'h1;       // The start bit is the first one taken.
						state_ff <= FR_HEAD;
						cand_ff  <= long_low;
					end
				end
				FR_HEAD:
					if (head_end)
						state_ff <= is_read ? FR_RDATA : FR_WDATA;
				FR_WDATA:
					if (frame_end)
						state_ff <= FR_IDLE;
				FR_RDATA:
					if (cnt_ff == `FRAME_LAST)
						state_ff <= FR_TAIL;
				FR_TAIL:
					cnt_ff <= cnt_ff;
			endcase
		end
		else if ((state_ff == FR_TAIL) & sclk_rise)
			state_ff <= FR_IDLE;
	end

	// ----------------------------------------
	// Read data driver, launched on rises.
	// ----------------------------------------
	// Drive starts at the rise after the eighth fall and stops at the
	// rise after the last, when the host has taken the final bit.
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rd_sh_ff <= 8'h00;
			oe_ff    <= 1'h0;
			dout_ff  <= 1'h0;
		end
		else if (head_end & is_read)
			rd_sh_ff <= rf_rdata;
		else if (sclk_rise & (state_ff == FR_RDATA))
		begin
			oe_ff    <= 1'h1;
			dout_ff  <= rd_sh_ff[7];
			rd_sh_ff <= {rd_sh_ff[6:0], 1'h0};
		end
		else if (state_ff != FR_RDATA & (sclk_rise | state_ff == FR_IDLE))
			oe_ff <= 1'h0;
	end

	assign sdat_o    = dout_ff;
	assign sdat_oe_o = oe_ff;

	// ----------------------------------------
	// Port enable and edge-start arming.
	// ----------------------------------------
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			port_on_ff <= 1'h1;
			armed_ff   <= 1'h0;
		end
		else if (is_reinit)
		begin
			port_on_ff <= 1'h1;
			armed_ff   <= 1'h0;
		end
		else if (is_off)
		begin
			port_on_ff <= 1'h0;
			armed_ff   <= 1'h1;
		end
	end

	// ----------------------------------------
	// Millisecond divider, free running.
	// ----------------------------------------
	localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);
	wire ms_tick = (ms_div_ff == MS_LAST);

	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			ms_div_ff <= 17'h00000;
		else
			ms_div_ff <= ms_tick ? 17'h00000 : ms_div_ff + 17'h00001;
	end

	// ----------------------------------------
	// Transmit mode: edge start, stop on low hold.
	// ----------------------------------------
	wire start_edge = rise_cfg_ff ? pe[0].rise : pe[0].fall;
	wire go         = armed_ff & start_edge & (mode_ff == MD_SLEEP);
	wire stop_due   = ms_tick & ~bit_in & (lo_ms_ff + 7'h01 >= stop_cfg_ff);

	// The low timer counts whole ms; up to one ms of early slack is
	// traded for a single shared divider.
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			mode_ff  <= MD_SLEEP;
			lo_ms_ff <= 7'h00;
			start_ff <= 1'h0;
			core_ff  <= 1'h0;
		end
		else
		begin
			start_ff <= go;
			core_ff  <= is_core;
			if (is_core)
				mode_ff <= MD_SLEEP;
			else if (go)
				mode_ff <= MD_TX;
			else if ((mode_ff == MD_TX) & stop_due)
				mode_ff <= MD_SLEEP;
			if (bit_in | (mode_ff == MD_SLEEP))
				lo_ms_ff <= 7'h00;
			else if (ms_tick)
				lo_ms_ff <= lo_ms_ff + 7'h01;
		end
	end

	assign tx_start_o   = start_ff;
	assign core_reset_o = core_ff;
	assign sleep_o      = (mode_ff == MD_SLEEP);

	// ----------------------------------------
	// AXI4-Lite slave: control and status words.
	// ----------------------------------------
	wire wr_go   = s_axi_awvalid & s_axi_wvalid & ~bvalid_ff;
	wire rd_go   = s_axi_arvalid & ~rvalid_ff;
	wire wr_ctrl = wr_go & (s_axi_awaddr == `OFS_CTRL);
	wire wr_map  = wr_ctrl | (s_axi_awaddr == `OFS_STATUS);
	wire [31:0] ctrl_word = {17'h0, stop_cfg_ff, 7'h0, rise_cfg_ff};
	wire [31:0] stat_word = {28'h0, sleep_o, mode_ff == MD_TX, armed_ff, port_on_ff};
	wire rd_ctrl = (s_axi_araddr == `OFS_CTRL);
	wire rd_stat = (s_axi_araddr == `OFS_STATUS);

	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_arready = ~rvalid_ff;

	// Control fields, written per byte lane.
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rise_cfg_ff <= `CTRL_RISE_RST;
			stop_cfg_ff <= `CTRL_STOP_RST;
		end
		else if (wr_ctrl)
		begin
			if (s_axi_wstrb[0])
				rise_cfg_ff <= s_axi_wdata[`CTRL_RISE_BIT];
			if (s_axi_wstrb[1])
				stop_cfg_ff <= s_axi_wdata[`CTRL_STOP_LSB +: 7];
		end
	end

	// Write and read answers; unmapped addresses get SLVERR.
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			bvalid_ff <= 1'h0;
			bresp_ff  <= `RESP_OKAY;
			rvalid_ff <= 1'h0;
			rresp_ff  <= `RESP_OKAY;
			rdata_ff  <= 32'h0;
		end
		else
		begin
			if (wr_go)
			begin
				bvalid_ff <= 1'h1;
				bresp_ff  <= wr_map ? `RESP_OKAY : `RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_ff <= 1'h0;
			if (rd_go)
			begin
				rvalid_ff <= 1'h1;
				rresp_ff  <= (rd_ctrl | rd_stat) ? `RESP_OKAY : `RESP_SLVERR;
				rdata_ff  <= rd_ctrl ? ctrl_word : (rd_stat ? stat_word : 32'h0);
			end
			else if (s_axi_rready)
				rvalid_ff <= 1'h0;
		end
	end

	assign s_axi_bvalid = bvalid_ff;
	assign s_axi_bresp  = bresp_ff;
	assign s_axi_rvalid = rvalid_ff;
	assign s_axi_rresp  = rresp_ff;
	assign s_axi_rdata  = rdata_ff;

	// ----------------------------------------
	// Assertions and covers.
	// ----------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);

	AST_FRAME_LEN:
	assert property (frame_end |=> state_ff == FR_IDLE && cnt_ff == 4'h0)
		else $error("write frame did not end after sixteen bits");

	AST_HEAD_INPUT:
	assert property (state_ff == FR_HEAD |-> !sdat_oe_o)
		else $error("data line driven during head bits");

	AST_FALL_SAMPLE:
	assert property ($changed(cnt_ff) |-> $past(sclk_fall))
		else $error("bit count moved without a clock fall");

	AST_READ_SELECT:
	assert property (head_end && is_read |=> state_ff == FR_RDATA ##0 rd_sh_ff == $past(rf_rdata))
		else $error("read head did not enter read data phase");

	AST_WRITE_STORE:
	assert property (is_wr |=> u_regs.mem_ff[$past(word[13:8])] == $past(word[7:0]))
		else $error("write frame did not store its data");

	AST_READ_DRIVE:
	assert property (sclk_rise && state_ff == FR_RDATA |=> sdat_oe_o && sdat_o == $past(rd_sh_ff[7]))
		else $error("read bit not driven at clock rise");

	AST_OFF_CMD:
	assert property (is_off |=> !port_on_ff && armed_ff)
		else $error("port-off command not obeyed");

	AST_CORE_SLEEP:
	assert property (is_core |=> core_reset_o && sleep_o ##1 !core_reset_o)
		else $error("core reset not a single pulse into sleep");

	AST_STOP_SLEEP:
	assert property (mode_ff == MD_TX && stop_due && !is_core |=> sleep_o)
		else $error("low hold did not end transmission");

	AST_REINIT:
	assert property (is_reinit |=> port_on_ff && !armed_ff)
		else $error("port-reset did not reinitialise the port");

	AST_NO_START:
	assert property (!armed_ff |=> !tx_start_o)
		else $error("transmission started while disarmed");

	AST_NO_STORE:
	assert property (is_off || is_core || is_reinit |-> !rf_wr.en)
		else $error("fixed command stored as a register write");

	COV_READ:   cover property (head_end && is_read ##[1:300] state_ff == FR_TAIL);
	COV_WRITE:  cover property (is_wr);
	COV_REINIT: cover property (is_reinit);
	COV_START:  cover property (tx_start_o ##[1:1000] sleep_o);

endmodule // two_wire_command_port

`default_nettype wire

// File: test/host_model.sv
// Host side of the two-wire port: drives the serial clock and the data line.
// Assumes the device drives the data line only while its enable is high.
`timescale 1ns/100ps
`default_nettype none

module host_model
(
	output logic      sclk_o,
	output wire logic line_o,
	input  wire logic dev_d_i,
	input  wire logic dev_oe_i
);
	// ----------------------------------------
	// Line state.
	// ----------------------------------------
	logic drv;    // High while the host drives the data line.
	logic val;    // Level the host drives.
	logic last;   // Last driven level, inverted once released.
	int   clash;  // Times both ends drove at once.

	// A released line with no pull shows the inverse of its last level, so stale data never reads back.
	assign line_o = dev_oe_i ? dev_d_i : (drv ? val : ~last);

	initial
	begin
		sclk_o = 1'b1;
		drv = 1'b1;
		val = 1'b0;
		last = 1'b0;
		clash = 0;
	end

	// The device must never switch on while the host still drives.
	always @(posedge dev_oe_i) if (drv) clash++;

	// ----------------------------------------
	// One bit: change at the rise, sample at the fall.
	// ----------------------------------------
	task automatic bit_io(input logic b, input logic rd, output logic s);
		sclk_o = 1'b1;
		if (rd)
		begin
			last = val;
			drv = 1'b0;
		end
		else val = b;
		#62.5;
		sclk_o = 1'b0;
		s = line_o;
		#62.5;
	endtask

	// Sixteen-bit frame, most significant first; reads release the line for the data half.
	task automatic frame(input logic [15:0] w, output logic [7:0] q);
		logic s;
		for (int i = 15; i >= 0; i--)
		begin
			bit_io(w[i], w[15:14] == 2'b11 && i < 8, s);
			if (i < 8) q[i] = s;
		end
		sclk_o = 1'b1;
		#60;
		drv = 1'b1;
		val = 1'b0;
		#100;
	endtask

	// Run of low data bits ahead of the port re-initialise word.
	task automatic lows(input int n);
		logic s;
		val = 1'b0;
		repeat (n) bit_io(1'b0, 1'b0, s);
	endtask
endmodule // host_model

`default_nettype wire

// File: test/tb_top.sv
// Self-checking bench for the two-wire command port.
// Assumes the host model drives the serial pins and the bench owns the register bus.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
	import two_wire_port_pkg::*;

	localparam int MS = 20;  // Shortened millisecond in clocks.

	logic        clock, reset_n;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	wire logic   sclk, line;
	logic        sdo, sdoe, tx_start, core_rst, sleep;
	logic [7:0]  q;
	int          fail_count, check_count, tx_n, core_n;

	// ----------------------------------------
	// Clock, reset, instances.
	// ----------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	host_model host (.sclk_o(sclk), .line_o(line), .dev_d_i(sdo), .dev_oe_i(sdoe));

	two_wire_command_port #(.MS_CYCLES(MS)) dut (.clock_i(clock), .reset_n_i(reset_n), .sclk_i(sclk),
		.sdat_i(line), .sdat_o(sdo), .sdat_oe_o(sdoe), .tx_start_o(tx_start), .core_reset_o(core_rst),
		.sleep_o(sleep), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready));

	// Count the one-cycle pulses so scenarios can judge them later.
	always @(posedge clock)
	begin
		if (tx_start === 1'b1) tx_n++;
		if (core_rst === 1'b1) core_n++;
	end

	// ----------------------------------------
	// Shared tasks.
	// ----------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e)
		begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask

	// Address and data go out together; each is dropped at the edge that takes it.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask

	task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clock);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk("rdata", ed, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask

	task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
		host.frame({2'b10, a, d}, q);
	endtask

	task automatic reg_rd(input logic [5:0] a, input logic [7:0] e);
		host.frame({2'b11, a, 8'h00}, q);
		chk("serial read", {24'h0, e}, {24'h0, q});
	endtask

	// ----------------------------------------
	// Scenarios.
	// ----------------------------------------
	task automatic t_reset();
		chk("oe", 32'h0, {31'h0, sdoe});
		chk("sleep", 32'h1, {31'h0, sleep});
		axi_rd(8'h00, 32'h0000_0201, 2'h0);
		axi_rd(8'h04, 32'h0000_0009, 2'h0);
		axi_rd(8'h08, 32'h0, 2'h2);
		axi_wr(8'h08, 32'h0000_00ff, 2'h2);
		axi_wr(8'h04, 32'h0000_000f, 2'h0);
		axi_rd(8'h04, 32'h0000_0009, 2'h0);
		axi_wr(8'h00, 32'h0000_7f01, 2'h0);
		axi_rd(8'h00, 32'h0000_7f01, 2'h0);
	endtask

	task automatic t_regs();
		logic [5:0] ad [4] = '{6'h3f, 6'h00, 6'h0d, 6'h05};
		logic [7:0] dv [4] = '{8'ha5, 8'h5a, 8'h11, 8'h77};
		reg_rd(6'h21, 8'h00);
		for (int i = 0; i < 4; i++) reg_wr(ad[i], dv[i]);
		for (int i = 0; i < 4; i++) reg_rd(ad[i], dv[i]);
		chk("oe after read", 32'h0, {31'h0, sdoe});
	endtask

	task automatic t_off();
		host.frame(16'h8d02, q);
		axi_rd(8'h04, 32'h0000_000a, 2'h0);
		host.val <= 1'b1;
		cyc(10);
		chk("tx start", 32'h1, tx_n);
		chk("sleep", 32'h0, {31'h0, sleep});
		axi_rd(8'h04, 32'h0000_0006, 2'h0);
	endtask

	task automatic t_reinit();
		// The closing low of the port-off word makes this run 31 long.
		host.lows(30);
		host.frame(16'h8d00, q);
		axi_rd(8'h04, 32'h0000_0006, 2'h0);
		host.lows(32);
		host.frame(16'h8d00, q);
		axi_rd(8'h04, 32'h0000_0005, 2'h0);
		reg_rd(6'h0d, 8'h11);
	endtask

	task automatic t_core();
		host.frame(16'hbd01, q);
		cyc(4);
		chk("core pulse", 32'h1, core_n);
		chk("sleep", 32'h1, {31'h0, sleep});
		axi_rd(8'h04, 32'h0000_0009, 2'h0);
		cyc(2 * MS);
		reg_rd(6'h05, 8'h00);
		reg_rd(6'h3d, 8'h00);
		host.val <= 1'b1;
		cyc(10);
		chk("no tx start", 32'h1, tx_n);
		host.val <= 1'b0;
		cyc(10);
	endtask

	task automatic t_stop();
		axi_wr(8'h00, 32'h0000_0201, 2'h0);
		host.frame(16'h8d02, q);
		host.val <= 1'b1;
		cyc(10);
		chk("tx start", 32'h2, tx_n);
		cyc(60);
		chk("sleep high data", 32'h0, {31'h0, sleep});
		host.val <= 1'b0;
		cyc(12);
		chk("sleep early", 32'h0, {31'h0, sleep});
		cyc(50);
		chk("sleep late", 32'h1, {31'h0, sleep});
		// Falling-edge start: a rise must not start, a fall must.
		axi_wr(8'h00, 32'h0000_0200, 2'h0);
		host.val <= 1'b1;
		cyc(10);
		chk("no rise start", 32'h2, tx_n);
		host.val <= 1'b0;
		cyc(10);
		chk("fall start", 32'h3, tx_n);
		chk("sleep fall start", 32'h0, {31'h0, sleep});
	endtask

	// ----------------------------------------
	// Sequence, watchdog, verdict.
	// ----------------------------------------
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hf;
		reset_n = 1'b0;
		{fail_count, check_count, tx_n, core_n} = '0;
		cyc(20);
		reset_n <= 1'b1;
		cyc(2);
		t_reset();
		t_regs();
		t_off();
		t_reinit();
		t_core();
		t_stop();
		chk("line clash", 32'h0, host.clash);
		finish_test();
	end

	// The whole run needs about 6k clocks; this cuts a hang well beyond that.
	initial
	begin
		#400000;
		fail_count++;
		finish_test();
	end
endmodule // tb_top

`default_nettype wire
